// ### verilog/tzba_cfg.svh
// Constants of the totalizer with batch alarms
// Functional notes
// RL1: Accumulate one selected source of four
// RL2: Decimal position setting from 0 to 4
// RL3: Samples below cut point are not added
// RL4: Time-base mode treats negative cut as zero
// RL5: Alarm type codes 0 to 3
// RL6: Alarm above positive or below negative setpoint
// RL7: Value alarm cleared by resets or initial load
// RL8: Continuous batch alarm held until reset command
// RL9: Pulse width code 0 to 4 decoded
// RL10: Pulse width at least selected, under 50 ms longer
// RL11: Type 3 resets total when alarm asserts
// RL12: Continuous auto-reset alarm kept until reset command
// RL13: Timed pulse ends after width regardless of reset
// RL14: Initial value at or above setpoint resets immediately
// RL15: Polarity bit selects energized or de-energized output
// RL16: Overflow resets total, optionally display flickers
// RL17: Time base second, minute, hour or day
// RL18: Divide by scale divisor, zero adds nothing
// RL19: Multiply by signed input multiplier
// RL20: Factor mode: factor after one hour full input
// RL21: Writing initial value loads the total
// RL22: Retransmission reaches 100 percent at scale value
// RL23: Reset command clears total and alarms, self-returns; a timed pulse in progress is not cut short, it runs out its width
// RL24: Hold stops everything, latch freezes display only (reset command, initial load and retransmission still act in hold)
// RL25: One contribution per fixed sampling period
`ifndef TZBA_CFG_SVH
`define TZBA_CFG_SVH

`define TZBA_OFS_CTRL        8'h00
`define TZBA_OFS_ALARM_CFG   8'h04
`define TZBA_OFS_CUT         8'h08
`define TZBA_OFS_FACTOR      8'h0c
`define TZBA_OFS_DIVISOR     8'h10
`define TZBA_OFS_MULTIPLIER  8'h14
`define TZBA_OFS_INITIAL     8'h18
`define TZBA_OFS_SP_ONE      8'h1c
`define TZBA_OFS_SP_TWO      8'h20
`define TZBA_OFS_RTX_SCALE   8'h24
`define TZBA_OFS_COMMAND     8'h28
`define TZBA_OFS_TOTAL       8'h2c
`define TZBA_OFS_STATUS      8'h30
`define TZBA_OFS_RTX_LEVEL   8'h34

`define TZBA_RST_CTRL        32'h0000_0000
`define TZBA_RST_ALARM_CFG   32'h0000_0000
`define TZBA_RST_FACTOR      32'h0000_0014
`define TZBA_RST_DIVISOR     32'h0000_0001
`define TZBA_RST_MULTIPLIER  32'h0000_0001
`define TZBA_RST_RTX_SCALE   32'h0000_2710

`define TZBA_MAX_DECIMALS    3'h4
`define TZBA_FULL_SCALE      64'sd10000
`define TZBA_TOTAL_MAX       32'sd9999999
`define TZBA_TOTAL_MIN       (-32'sd1999999)

`define TZBA_CLK_NS          50
`define TZBA_TICK_NS         10000000
`define TZBA_TICK_CYCLES     (`TZBA_TICK_NS / `TZBA_CLK_NS)
`define TZBA_SAMPLES_PER_SEC (1000000000 / `TZBA_TICK_NS)
`define TZBA_SEC_PER_MIN     60
`define TZBA_SEC_PER_HOUR    3600
`define TZBA_SEC_PER_DAY     86400
`define TZBA_PW_ONE_MS       100
`define TZBA_PW_TWO_MS       200
`define TZBA_PW_THREE_MS     500
`define TZBA_PW_FOUR_MS      1000

`endif

// ### verilog/tzba_pkg.sv
// Types of the totalizer with batch alarms
package tzba_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tzba_apb_req_type;

    typedef struct packed {
        logic signed [31:0] measurement_one;
        logic signed [31:0] measurement_two;
        logic signed [31:0] auxiliary_analog;
        logic signed [31:0] math_result;
    } tzba_src_type;

    typedef enum logic [1:0] {
        ALM_NONE       = 2'b00,
        ALM_VALUE      = 2'b01,
        ALM_BATCH      = 2'b10,
        ALM_BATCH_AUTO = 2'b11
    } tzba_alarm_kind_type;

    typedef enum logic [1:0] {
        RUN_ACTIVE = 2'b00,
        RUN_HOLD   = 2'b01,
        RUN_LATCH  = 2'b10
    } tzba_run_type;

    typedef enum logic [1:0] {
        AST_IDLE  = 2'b00,
        AST_PULSE = 2'b01,
        AST_CONT  = 2'b10,
        AST_SPENT = 2'b11
    } tzba_alarm_state_type;

    typedef struct packed {
        logic [1:0] spare;
        logic       polarity;
        logic [2:0] pulse_width;
        logic [1:0] kind;
    } tzba_alarm_cfg_type;

endpackage

// ### verilog/tzba_top.sv
// Totalizer with two batch alarms and retransmission, APB registers
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "tzba_cfg.svh"

module tzba_top #(
    parameter int unsigned TICK_CYCLES = `TZBA_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    // APB slave
    input  wire tzba_pkg::tzba_apb_req_type apb_req,
    output logic                            pready,
    output logic                            pslverr,
    output logic [31:0]                     prdata,
    // Process values
    input  wire tzba_pkg::tzba_src_type     sources,
    // Alarm pins, retransmission and display
    output logic [1:0]                      alarm_pin,
    output logic [13:0]                     retransmit_level,
    output logic [2:0]                      decimal_position,
    output logic                            display_flicker
);
    import tzba_pkg::*;

    // Reset release
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    function automatic logic alarm_cond(input logic signed [31:0] value,
                                        input logic signed [31:0] sp);
        alarm_cond = (sp > 0) ? (value > sp) : ((sp < 0) && (value < sp));
    endfunction

    function automatic logic [7:0] pulse_ticks(input logic [2:0] code);
        int unsigned ms;
        case (code)
            3'h1:    ms = `TZBA_PW_ONE_MS;
            3'h2:    ms = `TZBA_PW_TWO_MS;
            3'h3:    ms = `TZBA_PW_THREE_MS;
            default: ms = `TZBA_PW_FOUR_MS;
        endcase
        // Rounded up, plus one tick for the partial first period
        pulse_ticks = 8'((ms * 1000000 + `TZBA_TICK_NS - 1)
                         / `TZBA_TICK_NS + 1); // [RL9] [RL10]
    endfunction

    function automatic logic signed [63:0] samples_per_unit(
        input logic [1:0] tb);
        int unsigned secs;
        case (tb)
            2'h0:    secs = 1;
            2'h1:    secs = `TZBA_SEC_PER_MIN;
            2'h2:    secs = `TZBA_SEC_PER_HOUR;
            default: secs = `TZBA_SEC_PER_DAY;
        endcase
        samples_per_unit = 64'(secs) * 64'(`TZBA_SAMPLES_PER_SEC); // [RL17]
    endfunction

    // Configuration registers
    logic [11:0]        ctrl_reg, ctrl_next;
    tzba_alarm_cfg_type alarm_cfg_reg [2];
    tzba_alarm_cfg_type alarm_cfg_next [2];
    logic signed [31:0] cut_reg, cut_next;
    logic signed [31:0] factor_reg, factor_next;
    logic signed [31:0] div_reg, div_next;
    logic signed [31:0] mul_reg, mul_next;
    logic signed [31:0] init_reg, init_next;
    logic signed [31:0] sp_reg [2];
    logic signed [31:0] sp_next [2];
    logic signed [31:0] rtx_scale_reg, rtx_scale_next;
    logic [31:0]        prdata_reg, prdata_next;

    logic               access;
    logic               wr;
    logic               mapped;
    logic               init_load;
    logic               reset_cmd;
    logic [2:0]         dp_wr;
    logic [1:0]         src_sel;
    logic               tb_mode;
    logic [1:0]         time_base;
    logic               flicker_opt;
    logic [1:0]         run_mode;
    logic               rtx_total;

    assign src_sel     = ctrl_reg[1:0];
    assign tb_mode     = ctrl_reg[5];
    assign time_base   = ctrl_reg[7:6];
    assign flicker_opt = ctrl_reg[8];
    assign run_mode    = ctrl_reg[10:9];
    assign rtx_total   = ctrl_reg[11];

    // Status and accumulator state, read back below
    logic signed [31:0]   total_reg, total_next;
    logic signed [63:0]   frac_reg, frac_next;
    logic signed [31:0]   disp_reg, disp_next;
    logic                 flicker_reg, flicker_next;
    logic                 ovf_reg, ovf_next;
    logic [13:0]          rtx_reg, rtx_next;
    tzba_alarm_state_type ast_reg [2];
    tzba_alarm_state_type ast_next [2];
    logic [1:0]           alarm_reg, alarm_next;
    logic [7:0]           timer_reg [2];
    logic [7:0]           timer_next [2];
    logic [1:0]           auto_fire;

    assign access = apb_req.psel && apb_req.penable;
    assign wr     = access && apb_req.pwrite && mapped;
    always_comb
    begin
        mapped = (apb_req.paddr[1:0] == 2'h0)
                 && (apb_req.paddr <= `TZBA_OFS_RTX_LEVEL);
    end
    assign init_load = wr && (apb_req.paddr == `TZBA_OFS_INITIAL);
    // Command bit is a pulse, reads back zero
    assign reset_cmd = wr && (apb_req.paddr == `TZBA_OFS_COMMAND)
                       && apb_req.pwdata[0]; // [RL23]
    assign dp_wr = (apb_req.pwdata[4:2] > `TZBA_MAX_DECIMALS)
                   ? `TZBA_MAX_DECIMALS : apb_req.pwdata[4:2]; // [RL2]

    always_comb
    begin
        ctrl_next      = ctrl_reg;
        alarm_cfg_next = alarm_cfg_reg;
        cut_next       = cut_reg;
        factor_next    = factor_reg;
        div_next       = div_reg;
        mul_next       = mul_reg;
        init_next      = init_reg;
        sp_next        = sp_reg;
        rtx_scale_next = rtx_scale_reg;
        if (wr)
        begin
            case (apb_req.paddr)
                `TZBA_OFS_CTRL:
                    ctrl_next = {apb_req.pwdata[11:5], dp_wr,
                                 apb_req.pwdata[1:0]};
                `TZBA_OFS_ALARM_CFG:
                begin
                    alarm_cfg_next[0] = apb_req.pwdata[7:0];
                    alarm_cfg_next[1] = apb_req.pwdata[15:8];
                end
                `TZBA_OFS_CUT:        cut_next       = apb_req.pwdata;
                `TZBA_OFS_FACTOR:     factor_next    = apb_req.pwdata;
                `TZBA_OFS_DIVISOR:    div_next       = apb_req.pwdata;
                `TZBA_OFS_MULTIPLIER: mul_next       = apb_req.pwdata;
                `TZBA_OFS_INITIAL:    init_next      = apb_req.pwdata;
                `TZBA_OFS_SP_ONE:     sp_next[0]     = apb_req.pwdata;
                `TZBA_OFS_SP_TWO:     sp_next[1]     = apb_req.pwdata;
                `TZBA_OFS_RTX_SCALE:  rtx_scale_next = apb_req.pwdata;
                default:              ctrl_next      = ctrl_reg;
            endcase
        end
        // Read data captured in the setup phase
        prdata_next = prdata_reg;
        if (apb_req.psel && !apb_req.penable)
        begin
            case (apb_req.paddr)
                `TZBA_OFS_CTRL:       prdata_next = {20'h0, ctrl_reg};
                `TZBA_OFS_ALARM_CFG:
                    prdata_next = {16'h0, alarm_cfg_reg[1], alarm_cfg_reg[0]};
                `TZBA_OFS_CUT:        prdata_next = cut_reg;
                `TZBA_OFS_FACTOR:     prdata_next = factor_reg;
                `TZBA_OFS_DIVISOR:    prdata_next = div_reg;
                `TZBA_OFS_MULTIPLIER: prdata_next = mul_reg;
                `TZBA_OFS_INITIAL:    prdata_next = init_reg;
                `TZBA_OFS_SP_ONE:     prdata_next = sp_reg[0];
                `TZBA_OFS_SP_TWO:     prdata_next = sp_reg[1];
                `TZBA_OFS_RTX_SCALE:  prdata_next = rtx_scale_reg;
                `TZBA_OFS_TOTAL:      prdata_next = disp_reg;
                `TZBA_OFS_STATUS:
                    prdata_next = {27'h0, flicker_reg, ast_reg[1] != AST_IDLE,
                                   ast_reg[0] != AST_IDLE, alarm_reg};
                `TZBA_OFS_RTX_LEVEL:  prdata_next = {18'h0, rtx_reg};
                default:              prdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            ctrl_reg       <= 12'(`TZBA_RST_CTRL);
            alarm_cfg_reg  <= '{2{8'(`TZBA_RST_ALARM_CFG)}};
            cut_reg        <= 32'h0;
            factor_reg     <= `TZBA_RST_FACTOR;
            div_reg        <= `TZBA_RST_DIVISOR;
            mul_reg        <= `TZBA_RST_MULTIPLIER;
            init_reg       <= 32'h0;
            sp_reg         <= '{2{32'h0}};
            rtx_scale_reg  <= `TZBA_RST_RTX_SCALE;
            prdata_reg     <= 32'h0;
        end
        else
        begin
            ctrl_reg       <= ctrl_next;
            alarm_cfg_reg  <= alarm_cfg_next;
            cut_reg        <= cut_next;
            factor_reg     <= factor_next;
            div_reg        <= div_next;
            mul_reg        <= mul_next;
            init_reg       <= init_next;
            sp_reg         <= sp_next;
            rtx_scale_reg  <= rtx_scale_next;
            prdata_reg     <= prdata_next;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = prdata_reg;

    // Sampling period divider
    logic [31:0] tick_cnt_reg, tick_cnt_next;
    logic        tick;
    always_comb
    begin
        tick          = (tick_cnt_reg == 32'(TICK_CYCLES - 1)); // [RL25]
        tick_cnt_next = tick ? 32'h0 : tick_cnt_reg + 32'h1;
    end
    always_ff @(posedge core_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            tick_cnt_reg <= 32'h0;
        else
            tick_cnt_reg <= tick_cnt_next;
    end

    // Accumulator
    logic signed [31:0] sample;
    logic signed [31:0] cut_eff;
    logic signed [63:0] num;
    logic signed [63:0] den;
    logic signed [63:0] quo;
    logic signed [31:0] sum;
    logic               hold;
    logic [1:0]         auto_any;
    assign hold     = (run_mode == RUN_HOLD);
    assign auto_any = auto_fire;

    always_comb
    begin
        case (src_sel) // [RL1]
            2'h0:    sample = sources.measurement_one;
            2'h1:    sample = sources.measurement_two;
            2'h2:    sample = sources.auxiliary_analog;
            default: sample = sources.math_result;
        endcase
        cut_eff = (tb_mode && cut_reg < 0) ? 32'sh0 : cut_reg; // [RL4]
        if (tb_mode)
        begin
            num = frac_reg + 64'(sample) * 64'(mul_reg); // [RL19]
            den = 64'(div_reg) * samples_per_unit(time_base); // [RL18]
        end
        else
        begin
            num = frac_reg + 64'(sample) * 64'(factor_reg); // [RL20]
            den = `TZBA_FULL_SCALE
                  * samples_per_unit(2'h2);
        end
        quo = (den == 64'sh0) ? 64'sh0 : num / den;
        sum = total_reg + quo[31:0];
        total_next   = total_reg;
        frac_next    = frac_reg;
        flicker_next = flicker_reg;
        ovf_next     = 1'b0;
        if (reset_cmd)
        begin
            total_next   = 32'sh0; // [RL23]
            frac_next    = 64'sh0;
            flicker_next = 1'b0;
        end
        else if (|auto_any)
        begin
            total_next = 32'sh0; // [RL11] [RL14]
            frac_next  = 64'sh0;
        end
        else if (init_load)
        begin
            total_next = $signed(apb_req.pwdata); // [RL21]
            frac_next  = 64'sh0;
        end
        else if (tick && !hold && sample >= cut_eff
                 && den != 64'sh0) // [RL3] [RL18] [RL24]
        begin
            total_next = sum;
            frac_next  = num - quo * den;
            if (sum > `TZBA_TOTAL_MAX || sum < `TZBA_TOTAL_MIN)
            begin
                total_next   = 32'sh0; // [RL16]
                frac_next    = 64'sh0;
                ovf_next     = 1'b1;
                flicker_next = flicker_opt;
            end
        end
        disp_next = (run_mode == RUN_LATCH) ? disp_reg : total_next; // [RL24]
        rtx_next  = rtx_reg;
        if (tick)
        begin
            if (!rtx_total || rtx_scale_reg == 32'sh0
                || (64'(total_reg) * `TZBA_FULL_SCALE) / 64'(rtx_scale_reg)
                   <= 64'sh0)
                rtx_next = 14'h0;
            else if ((64'(total_reg) * `TZBA_FULL_SCALE)
                     / 64'(rtx_scale_reg) >= `TZBA_FULL_SCALE)
                rtx_next = 14'(`TZBA_FULL_SCALE);
            else
                rtx_next = 14'((64'(total_reg) * `TZBA_FULL_SCALE)
                               / 64'(rtx_scale_reg)); // [RL22]
        end
    end

    // Alarm sequencing
    always_comb
    begin
        ast_next   = ast_reg;
        alarm_next = alarm_reg;
        timer_next = timer_reg;
        auto_fire  = 2'b00;
        for (int i = 0; i < 2; i++)
        begin
            if (!hold && ast_reg[i] == AST_IDLE
                && alarm_cfg_reg[i].kind == ALM_BATCH_AUTO
                && (alarm_cond(total_reg, sp_reg[i])
                    || (init_load && sp_reg[i] > 0
                        && $signed(apb_req.pwdata) >= sp_reg[i])))
                auto_fire[i] = 1'b1; // [RL11] [RL14]
        end
        for (int i = 0; i < 2; i++)
        begin
            case (ast_reg[i])
                AST_IDLE:
                    if (!hold && alarm_cfg_reg[i].kind != ALM_NONE
                        && (alarm_cond(total_reg, sp_reg[i])
                            || auto_fire[i])) // [RL5] [RL6]
                    begin
                        alarm_next[i] = 1'b1;
                        if (alarm_cfg_reg[i].kind == ALM_VALUE
                            || alarm_cfg_reg[i].pulse_width == 3'h0)
                            ast_next[i] = AST_CONT; // [RL8] [RL12]
                        else
                        begin
                            ast_next[i]   = AST_PULSE;
                            timer_next[i] =
                                pulse_ticks(alarm_cfg_reg[i].pulse_width);
                        end
                    end
                AST_PULSE:
                    if (tick && !hold)
                    begin
                        timer_next[i] = timer_reg[i] - 8'h1;
                        if (timer_reg[i] == 8'h1)
                        begin
                            alarm_next[i] = 1'b0; // [RL13]
                            ast_next[i]   = AST_SPENT;
                        end
                    end
                AST_CONT:
                    if (reset_cmd
                        || (alarm_cfg_reg[i].kind == ALM_VALUE
                            && (ovf_reg || |auto_any
                                || (init_load && !alarm_cond(
                                    $signed(apb_req.pwdata), sp_reg[i])))))
                    begin
                        alarm_next[i] = 1'b0; // [RL7] [RL8] [RL12]
                        ast_next[i]   = AST_IDLE;
                    end
                AST_SPENT:
                    if (reset_cmd || !alarm_cond(total_reg, sp_reg[i]))
                        ast_next[i] = AST_IDLE;
                default:
                    ast_next[i] = AST_IDLE;
            endcase
            if (alarm_cfg_reg[i].kind == ALM_NONE)
            begin
                alarm_next[i] = 1'b0;
                ast_next[i]   = AST_IDLE;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            total_reg   <= 32'sh0;
            frac_reg    <= 64'sh0;
            disp_reg    <= 32'sh0;
            flicker_reg <= 1'b0;
            ovf_reg     <= 1'b0;
            rtx_reg     <= 14'h0;
            ast_reg     <= '{2{AST_IDLE}};
            alarm_reg   <= 2'b00;
            timer_reg   <= '{2{8'h0}};
        end
        else
        begin
            total_reg   <= total_next;
            frac_reg    <= frac_next;
            disp_reg    <= disp_next;
            flicker_reg <= flicker_next;
            ovf_reg     <= ovf_next;
            rtx_reg     <= rtx_next;
            ast_reg     <= ast_next;
            alarm_reg   <= alarm_next;
            timer_reg   <= timer_next;
        end
    end

    // Output drive, polarity applied per alarm
    always_comb
    begin
        alarm_pin = alarm_reg ^ {alarm_cfg_reg[1].polarity,
                                 alarm_cfg_reg[0].polarity}; // [RL15]
    end
    assign retransmit_level = rtx_reg;
    assign decimal_position = ctrl_reg[4:2];
    assign display_flicker  = flicker_reg;

endmodule
`default_nettype wire

// ### sim/tzba_checker_asserts.sv
// Checker of the totalizer APB port and outputs
`timescale 1ns/1ns
`default_nettype none
module tzba_checker
    import tzba_pkg::*;
(
    // Clock and reset
    input wire logic             core_clk,
    input wire logic             rst_n,
    // APB and outputs
    input wire tzba_apb_req_type apb_req,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [31:0]      prdata,
    input wire logic [13:0]      retransmit_level,
    input wire logic [2:0]       decimal_position
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic acc;
    logic bad;
    logic ctl;
    assign acc = apb_req.psel & apb_req.penable;
    assign bad = (apb_req.paddr > 8'h34) | (apb_req.paddr[1:0] != 2'h0);
    assign ctl = acc & apb_req.pwrite & (apb_req.paddr == 8'h00);
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_bad: assert property (acc && bad |-> pslverr)
        else $error("no error on unmapped access");
    a_err_good: assert property (acc && !bad |-> !pslverr)
        else $error("error on mapped access");
    a_err_rdata: assert property (acc && bad && !apb_req.pwrite |-> prdata == 0)
        else $error("read data on unmapped access");
    a_cmd_zero: assert property (acc && !apb_req.pwrite &&
        apb_req.paddr == 8'h28 |-> prdata == 0)
        else $error("command reads nonzero");
    a_dp_range: assert property (decimal_position <= 3'h4)
        else $error("decimal position above four");
    a_dp_write: assert property (ctl |=> decimal_position ==
        ($past(apb_req.pwdata[4:2]) > 3'h4 ? 3'h4 : $past(apb_req.pwdata[4:2])))
        else $error("decimal position not written");
    a_dp_kept: assert property (!ctl |=> $stable(decimal_position))
        else $error("decimal position moved");
    a_rtx_range: assert property (retransmit_level <= 14'd10000)
        else $error("retransmit above full scale");
endmodule
bind tzba_top tzba_checker tzba_checker_i (.core_clk(core_clk), .rst_n(rst_n),
    .apb_req(apb_req), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .retransmit_level(retransmit_level), .decimal_position(decimal_position));
`default_nettype wire

// ### sim/tzba_bench.sv
// Self-checking bench of the totalizer with batch alarms
`timescale 1ns/1ns
`default_nettype none
module totalizer_with_batch_alarms_bench;
    import tzba_pkg::*;
    logic             core_clk = 1'b0;
    logic             rst_n    = 1'b0;
    tzba_apb_req_type req      = '0;
    tzba_src_type     src      = '0;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic [1:0]       pin;
    logic [2:0]       dp;
    logic             flick;
    logic [13:0]      rtx;
    logic [31:0]      rd;
    int               failures = 0;
    int               checked  = 0;
    int               cyc      = 0;
    int               n;
    always #25 core_clk = ~core_clk;
    tzba_top #(.TICK_CYCLES(20)) tzba_top_i (.core_clk(core_clk),
        .rst_n(rst_n), .apb_req(req), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .sources(src), .alarm_pin(pin),
        .retransmit_level(rtx), .decimal_position(dp), .display_flicker(flick));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, result taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        req.penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rd = pslverr ? 32'hdead : prdata;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic wt(input int c);
        repeat (c) @(negedge core_clk);
    endtask
    task automatic t_regs;
        rc(8'h0c, 32'h14);
        rc(8'h10, 32'h1);
        rc(8'h14, 32'h1);
        rc(8'h24, 32'h2710);
        rc(8'h38, 32'hdead);
        rc(8'h28, 32'h0);
        wr(8'h00, 32'h1c);
        chk(32'(dp), 32'h4);
    endtask
    task automatic t_accum;
        @(posedge core_clk);
        src <= '{32'sd3000, 32'sd10000, 32'sd0, 32'sd0};
        wr(8'h00, 32'h121);
        wr(8'h28, 32'h1);
        wt(200);
        apb(1'b0, 8'h2c, 32'h0);
        chk(32'(rd % 100 == 0 && rd >= 800 && rd <= 1100), 1);
        wr(8'h10, 32'h0);
        wr(8'h28, 32'h1);
        wt(100);
        rc(8'h2c, 32'h0);
        wr(8'h10, 32'h1);
        wr(8'h08, 32'd20000);
        wr(8'h28, 32'h1);
        wt(100);
        rc(8'h2c, 32'h0);
        wr(8'h08, -32'sd10000);
        @(posedge core_clk);
        src.measurement_two <= -32'sd5000;
        wr(8'h28, 32'h1);
        wt(100);
        rc(8'h2c, 32'h0);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h321);
        wt(100);
        rc(8'h2c, 32'h0);
        @(posedge core_clk);
        src.measurement_two <= 32'sd10000;
        wr(8'h00, 32'h121);
        wr(8'h18, 32'd9999999);
        wt(60);
        chk(32'(flick), 1);
        @(posedge core_clk);
        src <= '0;
        // Hold with total retransmission: half the scale gives half output
        wr(8'h00, 32'ha00);
        wr(8'h18, 32'd5000);
        wt(30);
        chk(32'(rtx), 32'd5000);
        wr(8'h00, 32'h0);
    endtask
    task automatic t_value;
        wr(8'h04, 32'h01);
        wr(8'h1c, 32'd100);
        wr(8'h18, 32'd200);
        wt(2);
        chk(32'(pin), 1);
        wr(8'h04, 32'h21);
        chk(32'(pin), 0);
        wr(8'h28, 32'h1);
        chk(32'(pin), 1);
        rc(8'h2c, 32'h0);
        wr(8'h04, 32'h01);
        wr(8'h1c, -32'sd50);
        wr(8'h18, -32'sd100);
        wt(2);
        chk(32'(pin), 1);
        wr(8'h18, 32'h0);
        wt(2);
        chk(32'(pin), 0);
    endtask
    task automatic t_batch;
        wr(8'h04, 32'h0600);
        wr(8'h20, 32'd100);
        wr(8'h18, 32'd500);
        n = 0;
        while (pin[1] !== 1'b1 && n < 50)
        begin
            wt(1);
            n++;
        end
        wr(8'h28, 32'h1);
        n = 3;
        while (pin[1] === 1'b1 && n < 400)
        begin
            wt(1);
            n++;
        end
        chk(32'(n >= 198 && n <= 300), 1);
    endtask
    task automatic t_auto;
        wr(8'h04, 32'h03);
        wr(8'h1c, 32'd100);
        wr(8'h18, 32'd150);
        wt(60);
        chk(32'(pin), 1);
        rc(8'h2c, 32'h0);
        wr(8'h28, 32'h1);
        chk(32'(pin), 0);
    endtask
    task automatic tally_and_finish;
        $display("Compared %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            failures++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs;
        t_accum;
        t_value;
        t_batch;
        t_auto;
        tally_and_finish;
    end
endmodule
`default_nettype wire
